// [src/obtc_pkg.sv]
// package: constants for the option byte and trim configuration block
package obtc_pkg;
  localparam logic [15:0] OPT_ADDR0        = 16'h0000;
  localparam logic [15:0] OPT_ADDR1        = 16'h0001;
  localparam int          BIT_WDT_ACTION   = 7;
  localparam int          BIT_WATCHDOG_ALWAYS_ON       = 6;
  localparam int          BIT_RSV_HI       = 5;
  localparam int          BIT_RSV_LO       = 4;
  localparam int          BIT_BO_AO        = 3;
  localparam int          BIT_READ_PROT    = 2;
  localparam int          BIT_WRITE_PROT   = 0;
  localparam logic [7:0]  RSV_MASK         = 8'h30;
  localparam logic [7:0]  ERASED_VALUE     = 8'hFF;
  localparam logic [7:0]  TRIM_RESET       = 8'h00;
  // register indices; the bus byte address is four times the index
  localparam logic [11:0] OFS_OPTION_ZERO  = 12'h000;
  localparam logic [11:0] OFS_OPTION_ONE   = 12'h001;
  localparam logic [11:0] OFS_TRIM_DATA    = 12'hFF7;
  localparam logic [11:0] OFS_STATUS       = 12'h004;
  localparam logic [11:0] OFS_CONTROL      = 12'h005;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
  typedef enum logic [1:0] {
    LD_FETCH0 = 2'b00,
    LD_FETCH1 = 2'b01,
    LD_DONE   = 2'b11
  } obtc_load_t;
endpackage

// [src/obtc_loader.sv]
// option byte loader: reads the two option bytes after reset
`timescale 1ns/10ps
`default_nettype none
module obtc_loader
  import obtc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  output logic [15:0]      mem_addr_out,
  output logic             mem_rd_out,
  input  wire logic [7:0]  mem_data_in,
  output logic [7:0]       opt0_out,
  output logic [7:0]       opt1_out,
  output logic             done_out
);
  obtc_load_t state_reg;
  obtc_load_t state_next;
  logic [7:0] opt0_reg;
  logic [7:0] opt1_reg;
  // option latches are not reset; they are reloaded after every reset
  always_ff @(posedge ref_clk_in) begin
    if (state_reg == LD_FETCH0) opt0_reg <= mem_data_in | RSV_MASK;
    if (state_reg == LD_FETCH1) opt1_reg <= mem_data_in;
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) state_reg <= LD_FETCH0;
    else state_reg <= state_next;
  end
  always_comb begin
    case (state_reg)
      LD_FETCH0: state_next = LD_FETCH1;
      LD_FETCH1: state_next = LD_DONE;
      LD_DONE:   state_next = LD_DONE;
      default:   state_next = LD_FETCH0;
    endcase
  end
  // memory read is combinational with the address, one byte per cycle
  assign mem_addr_out = (state_reg == LD_FETCH1) ? OPT_ADDR1 : OPT_ADDR0;
  assign mem_rd_out   = (state_reg != LD_DONE);
  assign opt0_out     = opt0_reg;
  assign opt1_out     = opt1_reg;
  assign done_out     = (state_reg == LD_DONE);
endmodule
`default_nettype wire

// [src/obtc_wdt_ctl.sv]
// watchdog enable and timeout action policy from latched option bits
`timescale 1ns/10ps
`default_nettype none
module obtc_wdt_ctl
  import obtc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        cfg_valid_in,
  input  wire logic [7:0]  opt0_in,
  input  wire logic        start_instr_in,
  input  wire logic        stop_recovery_in,
  input  wire logic        timeout_in,
  input  wire logic        irq_enable_in,
  output logic             wdt_enable_out,
  output logic             wdt_irq_out,
  output logic             wdt_reset_out
);
  logic       run_reg;
  logic       irq_reg;
  logic       rst_reg;
  wire  logic always_on  = ~opt0_in[BIT_WATCHDOG_ALWAYS_ON];
  wire  logic act_reset  = opt0_in[BIT_WDT_ACTION];
  wire  logic running    = cfg_valid_in & (always_on | run_reg);
  wire  logic tmo        = running & timeout_in;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      run_reg <= 1'b0;
      irq_reg <= 1'b0;
      rst_reg <= 1'b0;
    end else begin
      // stop-mode recovery cannot disable an always-on watchdog
      if (cfg_valid_in && start_instr_in) run_reg <= 1'b1;
      else if (stop_recovery_in) run_reg <= 1'b0;
      // request held until interrupts are enabled and it is taken
      if (tmo && !act_reset) irq_reg <= 1'b1;
      else if (irq_enable_in) irq_reg <= 1'b0;
      rst_reg <= tmo & act_reset;
    end
  end
  assign wdt_enable_out = running;
  assign wdt_irq_out    = irq_reg & irq_enable_in;
  assign wdt_reset_out  = rst_reg;
endmodule
`default_nettype wire

// [src/obtc_top.sv]
// option byte and trim configuration block with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module obtc_top
  import obtc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  output logic [15:0]      mem_addr_out,
  output logic             mem_rd_out,
  input  wire logic [7:0]  mem_data_in,
  input  wire logic        start_instr_in,
  input  wire logic        stop_recovery_in,
  input  wire logic        timeout_in,
  input  wire logic        irq_enable_in,
  output logic             cpu_run_out,
  output logic             wdt_enable_out,
  output logic             wdt_irq_out,
  output logic             wdt_reset_out,
  output logic             brownout_on_out,
  output logic             read_protect_out,
  output logic             write_protect_out,
  output logic [7:0]       trim_out,
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic [7:0]  opt0;
  logic [7:0]  opt1;
  logic        cfg_done;
  logic [7:0]  trim_bit_data_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [13:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  obtc_loader u_loader (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .mem_addr_out (mem_addr_out),
    .mem_rd_out   (mem_rd_out),
    .mem_data_in  (mem_data_in),
    .opt0_out     (opt0),
    .opt1_out     (opt1),
    .done_out     (cfg_done)
  );

  obtc_wdt_ctl u_wdt (
    .ref_clk_in       (ref_clk_in),
    .rst_in           (rst_in),
    .cfg_valid_in     (cfg_done),
    .opt0_in          (opt0),
    .start_instr_in   (start_instr_in),
    .stop_recovery_in (stop_recovery_in),
    .timeout_in       (timeout_in),
    .irq_enable_in    (irq_enable_in),
    .wdt_enable_out   (wdt_enable_out),
    .wdt_irq_out      (wdt_irq_out),
    .wdt_reset_out    (wdt_reset_out)
  );

  // processor is held until the option latches are valid
  assign cpu_run_out       = cfg_done;
  // protection outputs gated until loaded, so stale latches never leak
  assign brownout_on_out   = cfg_done & ~opt0[BIT_BO_AO];
  assign read_protect_out  = cfg_done & ~opt0[BIT_READ_PROT];
  assign write_protect_out = cfg_done & ~opt0[BIT_WRITE_PROT];
  assign trim_out          = trim_bit_data_reg;

  // word decode: byte lanes within a word select the same register
  function automatic logic hit(input logic [13:0] a, input logic [11:0] idx);
    hit = (a[13:2] == idx);
  endfunction

  // write side: address and data taken in either order
  wire logic wr_go     = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire logic wr_trim   = hit(aw_addr_reg, OFS_TRIM_DATA);
  wire logic wr_ro     = hit(aw_addr_reg, OFS_OPTION_ZERO) | hit(aw_addr_reg, OFS_OPTION_ONE) |
                         hit(aw_addr_reg, OFS_STATUS);
  wire logic wr_ok     = wr_trim | wr_ro;
  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      aw_addr_reg <= 14'h0000;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // option latches are read-only here; they change only by reprogramming memory
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) trim_bit_data_reg <= TRIM_RESET;
    else if (wr_go && wr_trim && w_strb_reg[0]) trim_bit_data_reg <= w_data_reg[7:0];
  end

  // read side
  wire logic [13:0] ra = s_axi_araddr;
  wire logic rd_o0     = hit(ra, OFS_OPTION_ZERO);
  wire logic rd_o1     = hit(ra, OFS_OPTION_ONE);
  wire logic rd_tr     = hit(ra, OFS_TRIM_DATA);
  wire logic rd_st     = hit(ra, OFS_STATUS);
  wire logic [31:0] status_word = {26'h0, wdt_reset_out, wdt_irq_out, wdt_enable_out,
                                   read_protect_out, write_protect_out, cfg_done};
  wire logic [31:0] rd_mux =
      rd_o0 ? {24'h0, opt0 | RSV_MASK} :
      rd_o1 ? {24'h0, opt1} :
      rd_tr ? {24'h0, trim_bit_data_reg} :
      rd_st ? status_word : 32'h0000_0000;
  wire logic rd_ok     = rd_o0 | rd_o1 | rd_tr | rd_st;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dv/obtc_monitor.sv]
// checker for the option byte and trim configuration block
`timescale 1ns/10ps
`default_nettype none
module obtc_monitor (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic        mem_rd_out,
  input wire logic [7:0]  mem_data_in,
  input wire logic        start_instr_in,
  input wire logic        stop_recovery_in,
  input wire logic        timeout_in,
  input wire logic        irq_enable_in,
  input wire logic        cpu_run_out,
  input wire logic        wdt_enable_out,
  input wire logic        wdt_irq_out,
  input wire logic        wdt_reset_out,
  input wire logic        brownout_on_out,
  input wire logic        read_protect_out,
  input wire logic        write_protect_out,
  input wire logic [7:0]  trim_out
);
  logic [7:0] opt_reg;
  // raw copy of byte zero; only trusted once cpu_run_out is high
  always_ff @(posedge ref_clk_in) begin
    if (mem_rd_out && mem_addr_out == 16'h0000)
      opt_reg <= mem_data_in;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_fetch;
    mem_rd_out && mem_addr_out == 16'h0000 ##1 mem_rd_out && mem_addr_out == 16'h0001;
  endsequence
  property p_fetch; $fell(rst_in) |-> s_fetch; endproperty
  property p_load; $fell(rst_in) |-> s_fetch ##1 cpu_run_out; endproperty
  property p_act_reset;
    timeout_in && cpu_run_out && wdt_enable_out && opt_reg[7] |=> wdt_reset_out;
  endproperty
  property p_act_irq;
    timeout_in && cpu_run_out && wdt_enable_out && !opt_reg[7]
      |=> !wdt_reset_out && (!irq_enable_in || wdt_irq_out);
  endproperty
  // a shown request is taken at once unless a new timeout arrives
  property p_irq_gate;
    wdt_irq_out |-> irq_enable_in ##0 (timeout_in or (1'b1 ##1 !wdt_irq_out));
  endproperty
  property p_always_on; cpu_run_out && !opt_reg[6] |-> wdt_enable_out; endproperty
  property p_start; start_instr_in && cpu_run_out && opt_reg[6] |=> wdt_enable_out; endproperty
  property p_keep; wdt_enable_out && !stop_recovery_in |=> wdt_enable_out; endproperty
  property p_prot;
    cpu_run_out |-> {brownout_on_out, read_protect_out, write_protect_out}
                    == ~{opt_reg[3], opt_reg[2], opt_reg[0]};
  endproperty
  property p_trim; $fell(rst_in) |-> trim_out == 8'h00; endproperty
  a_fetch: assert property (p_fetch) else $error("option fetch order wrong");
  a_load: assert property (p_load) else $error("cpu run not after load");
  a_act_reset: assert property (p_act_reset) else $error("no reset on timeout");
  a_act_irq: assert property (p_act_irq) else $error("timeout request wrong");
  a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");
  a_always_on: assert property (p_always_on) else $error("watchdog not on");
  a_start: assert property (p_start) else $error("start ignored");
  a_keep: assert property (p_keep) else $error("watchdog dropped");
  a_prot: assert property (p_prot) else $error("protect outputs wrong");
  a_trim: assert property (p_trim) else $error("trim not cleared");
endmodule
bind obtc_top obtc_monitor u_mon (.*);
`default_nettype wire

// [dv/obtc_mem_model.sv]
// program memory model holding the two option bytes
`timescale 1ns/10ps
`default_nettype none
module obtc_mem_model (
  input wire logic        ref_clk_in,
  input wire logic [15:0] addr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  opt0_in,
  input wire logic [7:0]  opt1_in,
  output logic [7:0]      data_out
);
  logic flip_reg = 1'b0;
  // unread bus toggles so a stray sample never looks valid
  always @(posedge ref_clk_in) begin
    flip_reg <= ~flip_reg;
  end
  assign data_out = !rd_in ? {8{flip_reg}} : addr_in == 16'h0000 ? opt0_in :
                    addr_in == 16'h0001 ? opt1_in : {8{~flip_reg}};
endmodule
`default_nettype wire

// [dv/tb_option_byte_trim_config.sv]
// testbench for the option byte and trim configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_option_byte_trim_config;
  import obtc_pkg::*;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
  logic ref_clk_in = 1'b0, rst_in = 1'b1, start_instr_in = 1'b0, stop_recovery_in = 1'b0;
  logic timeout_in = 1'b0, irq_enable_in = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [7:0]  opt0 = 8'hFF, mem_data_in, trim_out;
  logic [15:0] mem_addr_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic mem_rd_out, cpu_run_out, wdt_enable_out, wdt_irq_out, wdt_reset_out;
  logic brownout_on_out, read_protect_out, write_protect_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_mismatch = 0, check_count = 0;
  obtc_top dut (.*);
  obtc_mem_model u_mem (.ref_clk_in(ref_clk_in), .addr_in(mem_addr_out), .rd_in(mem_rd_out),
    .opt0_in(opt0), .opt1_in(8'hFF), .data_out(mem_data_in));
  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 40) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk_in);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    bound(n);
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge ref_clk_in);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    bound(n);
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ed, s_axi_rdata)
  endtask
  // one-cycle event pulse; returns just after the edge that samples it
  task automatic ev(input logic [2:0] v);
    @(posedge ref_clk_in);
    {timeout_in, stop_recovery_in, start_instr_in} <= v;
    @(posedge ref_clk_in);
    {timeout_in, stop_recovery_in, start_instr_in} <= 3'b000;
    #1;
  endtask
  task automatic boot(input logic [7:0] o);
    @(posedge ref_clk_in);
    opt0 <= o;
    rst_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    `CHK("cpu_run", 1'b1, cpu_run_out)
  endtask
  initial begin
    boot(8'hFF);
    `CHK("wdt_en", 1'b0, wdt_enable_out)
    `CHK("prot", 3'b000, {brownout_on_out, read_protect_out, write_protect_out})
    rd(OFS_OPTION_ZERO, 32'h0000_00FF, RESP_OKAY);
    rd(OFS_TRIM_DATA, 32'h0000_0000, RESP_OKAY);
    wr(OFS_TRIM_DATA, 32'h0000_00A5, RESP_OKAY);
    rd(OFS_TRIM_DATA, 32'h0000_00A5, RESP_OKAY);
    `CHK("trim", 8'hA5, trim_out)
    wr(OFS_OPTION_ZERO, 32'h0000_0000, RESP_OKAY);
    rd(OFS_OPTION_ZERO, 32'h0000_00FF, RESP_OKAY);
    rd(OFS_CONTROL, 32'h0000_0000, RESP_SLVERR);
    ev(3'b001);
    `CHK("wdt_en", 1'b1, wdt_enable_out)
    rd(OFS_STATUS, 32'h0000_0009, RESP_OKAY);
    ev(3'b010);
    `CHK("wdt_en", 1'b0, wdt_enable_out)
    ev(3'b001);
    ev(3'b100);
    `CHK("wdt_rst", 1'b1, wdt_reset_out)
    boot(8'h32);
    `CHK("trim", 8'h00, trim_out)
    `CHK("wdt_en", 1'b1, wdt_enable_out)
    `CHK("prot", 3'b111, {brownout_on_out, read_protect_out, write_protect_out})
    rd(OFS_OPTION_ZERO, 32'h0000_0032, RESP_OKAY);
    ev(3'b010);
    `CHK("wdt_en", 1'b1, wdt_enable_out)
    ev(3'b100);
    `CHK("irq_rst", 2'b00, {wdt_irq_out, wdt_reset_out})
    @(posedge ref_clk_in);
    irq_enable_in <= 1'b1;
    #1;
    `CHK("irq", 1'b1, wdt_irq_out)
    boot(8'h32);
    rd(OFS_OPTION_ZERO, 32'h0000_0032, RESP_OKAY);
    test_done();
  end
endmodule
`default_nettype wire
